// ===== verilog/pior_consts.vh
// Constants for the peripheral I/O register map block
`ifndef PIOR_CONSTS_VH
`define PIOR_CONSTS_VH

// ----------------------------------------------------------------
// Access widths
// ----------------------------------------------------------------
`define PIOR_W1 2'h0
`define PIOR_W4 2'h1
`define PIOR_W8 2'h2

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define PIOR_A_LO 12'hF80
`define PIOR_A_SP 12'hF80
`define PIOR_A_RBS 12'hF82
`define PIOR_A_MBS 12'hF83
`define PIOR_A_SBS 12'hF84
`define PIOR_A_BTM 12'hF85
`define PIOR_A_BT 12'hF86
`define PIOR_A_TIMER2_HIGH_PERIOD_MODULO 12'hF88
`define PIOR_A_WDT 12'hF8B
`define PIOR_A_TM2 12'hF90
`define PIOR_A_TC2 12'hF92
`define PIOR_A_TC2H 12'hF93
`define PIOR_A_T2 12'hF94
`define PIOR_A_TIMER2_MODULO 12'hF96
`define PIOR_A_TM0 12'hFA0
`define PIOR_A_TIMER0_OUT_ENABLE 12'hFA2
`define PIOR_A_T0 12'hFA4
`define PIOR_A_TIMER0_MODULO 12'hFA6
`define PIOR_A_TM1 12'hFA8
`define PIOR_A_TIMER1_OUT_ENABLE 12'hFAA
`define PIOR_A_T1 12'hFAC
`define PIOR_A_TIMER1_MODULO 12'hFAE

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define PIOR_BIT3 2'h3
`define PIOR_RST8 8'h00
`define PIOR_RST4 4'h0
`define PIOR_RST3 3'h0
`define PIOR_RST2 2'h0
`define PIOR_RST1 1'h0
`define PIOR_SP_B0 1'h0
`define PIOR_ZERO8 8'h00
`define PIOR_ZERO4 4'h0
`define PIOR_ZERO7 7'h00
`define PIOR_ZERO1 1'h0
`define PIOR_ONE1 1'h1

// ----------------------------------------------------------------
// Legal bank choices
// ----------------------------------------------------------------
`define PIOR_RB_MAX 4'h3
`define PIOR_MB_0 4'h0
`define PIOR_MB_4 4'h4
`define PIOR_MB_15 4'hF

`endif

// ===== verilog/pior_bank.v
// Register and memory bank choice registers loaded by the choose instruction
`timescale 1ns/1ps
`include "pior_consts.vh"

module pior_bank
(
  input wire clk_i, // CPU clock
  input wire arst_n_i, // Async reset, active low
  input wire sel_rb_i, // Choose register bank strobe
  input wire sel_mb_i, // Choose memory bank strobe
  input wire [3:0] sel_val_i, // Bank number to choose
  output wire [3:0] register_bank_o, // Current register bank choice
  output wire [3:0] memory_bank_o // Current memory bank choice
);

  reg [3:0] rb_q;
  reg [3:0] mb_q;
  wire rb_ok;
  wire mb_ok;

  // ----------------------------------------------------------------
  // Value screening
  // ----------------------------------------------------------------
  // screen bank values
  assign rb_ok = (sel_val_i <= `PIOR_RB_MAX);
  assign mb_ok = (sel_val_i == `PIOR_MB_0) || (sel_val_i == `PIOR_MB_4) ||
                 (sel_val_i == `PIOR_MB_15);

  // Load on choose strobes; out-of-range values leave the choice alone
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rb_q <= `PIOR_RST4;
      mb_q <= `PIOR_RST4;
    end
    else
    begin
      if (sel_rb_i && rb_ok)
        rb_q <= sel_val_i;
      if (sel_mb_i && mb_ok)
        mb_q <= sel_val_i;
    end
  end

  assign register_bank_o = rb_q;
  assign memory_bank_o = mb_q;

endmodule // pior_bank

// ===== verilog/pior_top.v
// Peripheral I/O register map seen from the CPU data memory path
`timescale 1ns/1ps
`include "pior_consts.vh"

module pior_top
(
  input wire clk_i, // CPU clock, 125 MHz
  input wire arst_n_i, // Async reset, active low
  input wire [11:0] addr_i, // Data memory address
  input wire [1:0] width_i, // Access width: 1, 4 or 8 bits
  input wire [1:0] bit_i, // Bit position for 1-bit access
  input wire wr_i, // Write strobe
  input wire rd_i, // Read strobe
  input wire [7:0] wdata_i, // Write data, low bits used for narrow access
  output wire [7:0] rdata_o, // Read data, one cycle after rd_i
  output wire rvalid_o, // Read data valid pulse
  input wire sel_rb_i, // Choose register bank strobe
  input wire sel_mb_i, // Choose memory bank strobe
  input wire [3:0] sel_val_i, // Bank number for the choose strobes
  input wire [7:0] itv_count_i, // Interval timer count from timer logic
  input wire [7:0] t0_count_i, // Timer 0 count
  input wire [7:0] t1_count_i, // Timer 1 count
  input wire [7:0] t2_count_i, // Timer 2 count
  input wire t0_raw_i, // Timer 0 output before gating
  input wire t1_raw_i, // Timer 1 output before gating
  input wire t2_raw_i, // Timer 2 output before gating
  output wire [7:0] stack_pointer_o, // Stack pointer
  output wire [3:0] register_bank_o, // Register bank choice
  output wire [3:0] memory_bank_o, // Memory bank choice
  output wire [3:0] stack_bank_o, // Stack bank choice
  output wire [3:0] interval_timer_mode_o, // Interval timer mode
  output wire watchdog_enable_o, // Watchdog enable flag
  output wire [7:0] timer2_high_modulo_o, // Timer 2 high-period modulo
  output wire [7:0] timer0_mode_o, // Timer 0 mode
  output wire [7:0] timer1_mode_o, // Timer 1 mode
  output wire [7:0] timer2_mode_o, // Timer 2 mode
  output wire [7:0] timer0_modulo_o, // Timer 0 modulo
  output wire [7:0] timer1_modulo_o, // Timer 1 modulo
  output wire [7:0] timer2_modulo_o, // Timer 2 modulo
  output wire [2:0] timer2_control_o, // Timer 2 carrier, level buffer, level
  output wire [2:0] timer2_control_hi_o, // Timer 2 upper control bits 2..0
  output wire [2:0] timer_out_enable_o, // Output enables of timers 2..0
  output wire [2:0] timer_pin_o // Gated timer pins 2..0
);

  // ----------------------------------------------------------------
  // Access qualifiers
  // ----------------------------------------------------------------
  wire wr1;
  wire wr4;
  wire wr8;
  wire rd1;
  wire rd4;
  wire rd8;
  wire bit3;
  wire even;
  wire [7:0] counts [0:2];
  wire [2:0] raw;
  wire [23:0] mode_flat;
  wire [23:0] modulo_flat;

  // byte access at even address only
  assign even = ~addr_i[0];
  assign wr1 = wr_i && (width_i == `PIOR_W1);
  assign wr4 = wr_i && (width_i == `PIOR_W4);
  assign wr8 = wr_i && (width_i == `PIOR_W8) && even;
  assign rd1 = rd_i && (width_i == `PIOR_W1);
  assign rd4 = rd_i && (width_i == `PIOR_W4);
  assign rd8 = rd_i && (width_i == `PIOR_W8) && even;
  assign bit3 = (bit_i == `PIOR_BIT3);
  assign counts[0] = t0_count_i;
  assign counts[1] = t1_count_i;
  assign counts[2] = t2_count_i;
  assign raw = {t2_raw_i, t1_raw_i, t0_raw_i};

  // ----------------------------------------------------------------
  // Bank choice registers
  // ----------------------------------------------------------------
  pior_bank u_bank
  (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .sel_rb_i(sel_rb_i),
    .sel_mb_i(sel_mb_i),
    .sel_val_i(sel_val_i),
    .register_bank_o(register_bank_o),
    .memory_bank_o(memory_bank_o)
  );

  // ----------------------------------------------------------------
  // Stand-alone registers
  // ----------------------------------------------------------------
  reg [6:0] sp_q;
  reg [3:0] sbs_q;
  reg [3:0] btm_q;
  reg wdt_q;
  reg [7:0] timer2_high_period_modulo_q;
  reg [2:0] tc2_q;
  reg [2:0] tc2h_q;

  // Stack pointer, upper seven bits only
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sp_q <= `PIOR_ZERO7;
    else if (wr8 && addr_i == `PIOR_A_SP)
      sp_q <= wdata_i[7:1];
  end

  // Stack bank, nibble access only
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      sbs_q <= `PIOR_RST4;
    else if (wr4 && addr_i == `PIOR_A_SBS)
      sbs_q <= wdata_i[3:0];
  end

  // Interval timer mode, nibble or bit 3 alone
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      btm_q <= `PIOR_RST4;
    else if (wr4 && addr_i == `PIOR_A_BTM)
      btm_q <= wdata_i[3:0];
    else if (wr1 && bit3 && addr_i == `PIOR_A_BTM)
      btm_q[3] <= wdata_i[0];
  end

  // Watchdog enable, set by a 1-bit write of one at bit 3
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wdt_q <= `PIOR_RST1;
    else if (wr1 && bit3 && addr_i == `PIOR_A_WDT && wdata_i[0])
      wdt_q <= `PIOR_ONE1;
  end

  // Timer 2 high-period modulo, byte only
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      timer2_high_period_modulo_q <= `PIOR_RST8;
    else if (wr8 && addr_i == `PIOR_A_TIMER2_HIGH_PERIOD_MODULO)
      timer2_high_period_modulo_q <= wdata_i;
  end

  // Timer 2 control: low nibble bits 2..0 by 1, 4 or 8 bits
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tc2_q <= `PIOR_RST3;
      tc2h_q <= `PIOR_RST3;
    end
    else if (wr8 && addr_i == `PIOR_A_TC2)
    begin
      tc2_q <= wdata_i[2:0];
      tc2h_q <= wdata_i[6:4];
    end
    else if (wr4 && addr_i == `PIOR_A_TC2)
      tc2_q <= wdata_i[2:0];
    else if (wr1 && !bit3 && addr_i == `PIOR_A_TC2)
      tc2_q[bit_i] <= wdata_i[0];
  end

  // ----------------------------------------------------------------
  // Timer channels 0, 1 and 2
  // ----------------------------------------------------------------
  wire [2:0] oe_q;
  wire [2:0] pin_q;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_tmr
      localparam [11:0] MODE_A = (g == 0) ? `PIOR_A_TM0 :
                                 (g == 1) ? `PIOR_A_TM1 : `PIOR_A_TM2;
      localparam [11:0] MOD_A = (g == 0) ? `PIOR_A_TIMER0_MODULO :
                                (g == 1) ? `PIOR_A_TIMER1_MODULO : `PIOR_A_TIMER2_MODULO;
      localparam [11:0] OE_A = (g == 0) ? `PIOR_A_TIMER0_OUT_ENABLE :
                               (g == 1) ? `PIOR_A_TIMER1_OUT_ENABLE : `PIOR_A_TC2;
      localparam WIDE_OE = (g == 2);
      reg [7:0] mode_q;
      reg [7:0] mod_q;
      reg oe_bit_q;
      reg pin_bit_q;

      // Mode register, byte or bit 3 alone
      always @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          mode_q <= `PIOR_RST8;
        else if (wr8 && addr_i == MODE_A)
          mode_q <= wdata_i;
        else if (wr1 && bit3 && addr_i == MODE_A)
          mode_q[3] <= wdata_i[0];
      end

      // Modulo register, byte only
      always @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          mod_q <= `PIOR_RST8;
        else if (wr8 && addr_i == MOD_A)
          mod_q <= wdata_i;
      end

      // Output enable: bit 3 write; timer 2 also by nibble or byte
      always @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          oe_bit_q <= `PIOR_RST1;
        else if (wr1 && bit3 && addr_i == OE_A)
          oe_bit_q <= wdata_i[0];
        else if (WIDE_OE && (wr4 || wr8) && addr_i == OE_A)
          oe_bit_q <= wdata_i[3];
      end

      // Gated timer pin
      always @(posedge clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          pin_bit_q <= `PIOR_RST1;
        else
          pin_bit_q <= raw[g] & oe_bit_q;
      end

      // One driver per bit of the shared vectors
      assign oe_q[g] = oe_bit_q;
      assign pin_q[g] = pin_bit_q;

      assign mode_flat[8*g+:8] = mode_q;
      assign modulo_flat[8*g+:8] = mod_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  reg [7:0] rd_d;
  reg [7:0] rdata_q;
  reg rvalid_q;

  // Select read data; write-only and unmapped places read zero
  always @*
  begin
    rd_d = `PIOR_ZERO8;
    case (addr_i)
      `PIOR_A_SP:
        if (rd8)
          rd_d = {sp_q, `PIOR_SP_B0};
      `PIOR_A_RBS:
        if (rd4)
          rd_d = {`PIOR_ZERO4, register_bank_o};
        else if (rd8)
          rd_d = {memory_bank_o, register_bank_o};
      `PIOR_A_MBS:
        if (rd4)
          rd_d = {`PIOR_ZERO4, memory_bank_o};
      `PIOR_A_SBS:
        if (rd4)
          rd_d = {`PIOR_ZERO4, sbs_q};
      `PIOR_A_BT:
        if (rd8)
          rd_d = itv_count_i;
      `PIOR_A_TIMER2_HIGH_PERIOD_MODULO:
        if (rd8)
          rd_d = timer2_high_period_modulo_q;
      `PIOR_A_TM2:
        if (rd8)
          rd_d = mode_flat[23:16];
      `PIOR_A_TC2:
        if (rd8)
          rd_d = {`PIOR_ZERO1, tc2h_q, `PIOR_ZERO1, tc2_q};
        else if (rd4)
          rd_d = {`PIOR_ZERO4, `PIOR_ZERO1, tc2_q};
        else if (rd1 && !bit3)
          rd_d = {`PIOR_ZERO7, tc2_q[bit_i]};
      `PIOR_A_T2:
        if (rd8)
          rd_d = counts[2];
      `PIOR_A_TIMER2_MODULO:
        if (rd8)
          rd_d = modulo_flat[23:16];
      `PIOR_A_TM0:
        if (rd8)
          rd_d = mode_flat[7:0];
      `PIOR_A_T0:
        if (rd8)
          rd_d = counts[0];
      `PIOR_A_TIMER0_MODULO:
        if (rd8)
          rd_d = modulo_flat[7:0];
      `PIOR_A_TM1:
        if (rd8)
          rd_d = mode_flat[15:8];
      `PIOR_A_T1:
        if (rd8)
          rd_d = counts[1];
      `PIOR_A_TIMER1_MODULO:
        if (rd8)
          rd_d = modulo_flat[15:8];
      default:
        rd_d = `PIOR_ZERO8;
    endcase
  end

  // Register read data one cycle after the strobe
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_q <= `PIOR_RST8;
      rvalid_q <= `PIOR_RST1;
    end
    else
    begin
      rvalid_q <= rd_i;
      if (rd_i)
        rdata_q <= (addr_i >= `PIOR_A_LO) ? rd_d : `PIOR_ZERO8;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign stack_pointer_o = {sp_q, `PIOR_SP_B0};
  assign stack_bank_o = sbs_q;
  assign interval_timer_mode_o = btm_q;
  assign watchdog_enable_o = wdt_q;
  assign timer2_high_modulo_o = timer2_high_period_modulo_q;
  assign timer0_mode_o = mode_flat[7:0];
  assign timer1_mode_o = mode_flat[15:8];
  assign timer2_mode_o = mode_flat[23:16];
  assign timer0_modulo_o = modulo_flat[7:0];
  assign timer1_modulo_o = modulo_flat[15:8];
  assign timer2_modulo_o = modulo_flat[23:16];
  assign timer2_control_o = tc2_q;
  assign timer2_control_hi_o = tc2h_q;
  assign timer_out_enable_o = oe_q;
  assign timer_pin_o = pin_q;

endmodule // pior_top

// ===== tb/pior_monitor.sv
// Checker on the ports of the peripheral register map
`timescale 1ns/1ps
module pior_monitor
(
  input wire clk_i, // CPU clock
  input wire arst_n_i, // Reset, active low
  input wire [11:0] addr_i, // Address
  input wire [1:0] width_i, // Access width
  input wire [1:0] bit_i, // Bit position
  input wire wr_i, // Write strobe
  input wire rd_i, // Read strobe
  input wire [7:0] wdata_i, // Write data
  input wire [7:0] rdata_o, // Read data
  input wire [7:0] t0_count_i, // Timer 0 count
  input wire t0_raw_i, // Timer 0 raw output
  input wire t1_raw_i, // Timer 1 raw output
  input wire t2_raw_i, // Timer 2 raw output
  input wire [7:0] stack_pointer_o, // Stack pointer
  input wire [3:0] register_bank_o, // Register bank
  input wire [3:0] memory_bank_o, // Memory bank
  input wire watchdog_enable_o, // Watchdog flag
  input wire [7:0] timer0_mode_o, // Timer 0 mode
  input wire [2:0] timer_out_enable_o, // Output enables
  input wire [2:0] timer_pin_o // Gated pins
);
  // One clock domain for every property
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  property p_sp_wr;
    wr_i && addr_i == 12'hF80 && width_i == 2'h2 |=> stack_pointer_o == ($past(wdata_i) & 8'hFE);
  endproperty
  a_sp_wr: assert property (p_sp_wr) else $error("stack pointer write wrong");
  property p_sp_narrow;
    wr_i && addr_i == 12'hF80 && width_i != 2'h2 |=> $stable(stack_pointer_o);
  endproperty
  a_sp_narrow: assert property (p_sp_narrow) else $error("stack pointer narrow write");
  property p_wdt_keep;
    watchdog_enable_o |=> watchdog_enable_o;
  endproperty
  a_wdt_keep: assert property (p_wdt_keep) else $error("watchdog flag cleared");
  property p_wdt_set;
    wr_i && addr_i == 12'hF8B && width_i == 2'h0 && bit_i == 2'h3 && wdata_i[0] |=> watchdog_enable_o;
  endproperty
  a_wdt_set: assert property (p_wdt_set) else $error("watchdog flag not set");
  property p_bank_byte;
    rd_i && addr_i == 12'hF82 && width_i == 2'h2
      |=> rdata_o == {$past(memory_bank_o), $past(register_bank_o)};
  endproperty
  a_bank_byte: assert property (p_bank_byte) else $error("bank byte read wrong");
  property p_bank_legal;
    register_bank_o <= 4'h3 && memory_bank_o inside {4'h0, 4'h4, 4'hF};
  endproperty
  a_bank_legal: assert property (p_bank_legal) else $error("illegal bank value");
  property p_mode_bit;
    wr_i && addr_i == 12'hFA0 && width_i == 2'h0 && bit_i != 2'h3 |=> $stable(timer0_mode_o);
  endproperty
  a_mode_bit: assert property (p_mode_bit) else $error("mode bit write taken");
  property p_count;
    rd_i && addr_i == 12'hFA4 && width_i == 2'h2 |=> rdata_o == $past(t0_count_i);
  endproperty
  a_count: assert property (p_count) else $error("count read wrong");
  property p_pin;
    timer_pin_o == $past({t2_raw_i, t1_raw_i, t0_raw_i} & timer_out_enable_o);
  endproperty
  a_pin: assert property (p_pin) else $error("timer pin gating wrong");
  property p_unmounted;
    rd_i && addr_i == 12'hF8A |=> rdata_o == 8'h00;
  endproperty
  a_unmounted: assert property (p_unmounted) else $error("unmounted read not zero");
endmodule // pior_monitor

bind pior_top pior_monitor u_mon (.clk_i, .arst_n_i, .addr_i, .width_i, .bit_i, .wr_i, .rd_i,
  .wdata_i, .rdata_o, .t0_count_i, .t0_raw_i, .t1_raw_i, .t2_raw_i, .stack_pointer_o,
  .register_bank_o, .memory_bank_o, .watchdog_enable_o, .timer0_mode_o, .timer_out_enable_o,
  .timer_pin_o);

// ===== tb/pior_cpu_model.sv
// CPU data memory access path that drives the register map
`timescale 1ns/1ps
module pior_cpu_model
(
  input wire clk_i, // CPU clock
  input wire [7:0] rdata_i, // Read data
  input wire rvalid_i, // Read data valid
  output reg [11:0] addr_o, // Address
  output reg [1:0] width_o, // Access width
  output reg [1:0] bit_o, // Bit position
  output reg wr_o, // Write strobe
  output reg rd_o, // Read strobe
  output reg [7:0] wdata_o // Write data
);
  // Idle bus at time zero
  initial
  begin
    addr_o = 12'h000;
    width_o = 2'h0;
    bit_o = 2'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // plain memory access
  // One request held over the taking edge, read data taken while valid
  task xfer(input logic [11:0] a, input logic [1:0] w, input logic [1:0] b, input logic we,
    input logic [7:0] v, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    width_o = w;
    bit_o = b;
    wdata_o = v;
    wr_o = we;
    rd_o = !we;
    @(negedge clk_i);
    d = rvalid_i ? rdata_i : 8'hXX;
    wr_o = 1'b0;
    rd_o = 1'b0;
    // Released address, data and bit lines must not keep their old values
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
    bit_o = ~bit_o;
  endtask
endmodule // pior_cpu_model

// ===== tb/peripheral_io_register_map_tb_top.sv
// Testbench for the peripheral register map
`timescale 1ns/1ps
module peripheral_io_register_map_tb_top;
  reg clk_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg sel_rb_i = 1'b0;
  reg sel_mb_i = 1'b0;
  reg [3:0] sel_val_i = 4'h0;
  reg [7:0] itv_count_i = 8'h00;
  reg [7:0] t0_count_i = 8'h00;
  reg [7:0] t1_count_i = 8'h00;
  reg [7:0] t2_count_i = 8'h00;
  reg t0_raw_i = 1'b0;
  reg t1_raw_i = 1'b0;
  reg t2_raw_i = 1'b0;
  wire [11:0] addr_i;
  wire [1:0] width_i;
  wire [1:0] bit_i;
  wire wr_i;
  wire rd_i;
  wire [7:0] wdata_i;
  wire [7:0] rdata_o;
  wire rvalid_o;
  wire [7:0] stack_pointer_o;
  wire [3:0] register_bank_o;
  wire [3:0] memory_bank_o;
  wire [3:0] interval_timer_mode_o;
  wire watchdog_enable_o;
  wire [2:0] timer2_control_o;
  wire [2:0] timer2_control_hi_o;
  wire [2:0] timer_out_enable_o;
  wire [2:0] timer_pin_o;
  int fails = 0;
  int samples_checked = 0;
  int i;
  int b;
  int rb;
  int mb;
  logic [7:0] d;
  logic [7:0] e;
  logic [7:0] mem [int];
  int rw8[$] = '{12'hF88, 12'hF90, 12'hF96, 12'hFA0, 12'hFA6, 12'hFA8, 12'hFAE};
  int md[$] = '{12'hF90, 12'hFA0, 12'hFA8};

  // Free-running 125 MHz clock
  always #4 clk_i = ~clk_i;

  pior_cpu_model cpu (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o), .addr_o(addr_i),
    .width_o(width_i), .bit_o(bit_i), .wr_o(wr_i), .rd_o(rd_i), .wdata_o(wdata_i));

  pior_top dut (.clk_i, .arst_n_i, .addr_i, .width_i, .bit_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
    .rvalid_o, .sel_rb_i, .sel_mb_i, .sel_val_i, .itv_count_i, .t0_count_i, .t1_count_i,
    .t2_count_i, .t0_raw_i, .t1_raw_i, .t2_raw_i, .stack_pointer_o, .register_bank_o,
    .memory_bank_o, .stack_bank_o(), .interval_timer_mode_o, .watchdog_enable_o,
    .timer2_high_modulo_o(), .timer0_mode_o(), .timer1_mode_o(), .timer2_mode_o(),
    .timer0_modulo_o(), .timer1_modulo_o(), .timer2_modulo_o(), .timer2_control_o,
    .timer2_control_hi_o, .timer_out_enable_o, .timer_pin_o);

  // Compare one value and count it
  task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus write and checked bus read
  task w(input logic [11:0] a, input logic [1:0] wd, input logic [1:0] bp, input logic [7:0] v);
    cpu.xfer(a, wd, bp, 1'b1, v, d);
  endtask
  task r(input logic [11:0] a, input logic [1:0] wd, input logic [7:0] x);
    cpu.xfer(a, wd, 2'h0, 1'b0, 8'h00, d);
    check($sformatf("read %h", a), d, x);
  endtask
  // Verdict and end of run
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the expected run
  initial
  begin
    #60000;
    fails++;
    summarize;
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    arst_n_i = 1'b1;
    i = $urandom(32'h7292);
    // byte registers reset and read back
    foreach (rw8[k])
    begin
      r(rw8[k], 2'h2, 8'h00);
      mem[rw8[k]] = 8'($urandom);
      w(rw8[k], 2'h2, 2'h0, mem[rw8[k]]);
      r(rw8[k], 2'h2, mem[rw8[k]]);
    end
    e = 8'($urandom) | 8'h01;
    w(12'hF80, 2'h2, 2'h0, e);
    check("sp", stack_pointer_o, e & 8'hFE);
    w(12'hF80, 2'h1, 2'h0, 8'h00);
    w(12'hF80, 2'h3, 2'h0, 8'h00);
    r(12'hF80, 2'h2, e & 8'hFE);
    r(12'hF8B, 2'h0, 8'h00);
    w(12'hF8B, 2'h0, 2'h3, 8'h00);
    check("wdt", {7'h00, watchdog_enable_o}, 8'h00);
    w(12'hF8B, 2'h0, 2'h3, 8'h01);
    w(12'hF8B, 2'h0, 2'h3, 8'h00);
    w(12'hF8B, 2'h1, 2'h0, 8'h00);
    check("wdt", {7'h00, watchdog_enable_o}, 8'h01);
    // every bank value offered, illegal ones refused
    rb = 0;
    mb = 0;
    for (i = 0; i < 16; i++)
    begin
      sel_val_i = i[3:0];
      sel_rb_i = 1'b1;
      @(negedge clk_i);
      sel_rb_i = 1'b0;
      sel_mb_i = 1'b1;
      @(negedge clk_i);
      sel_mb_i = 1'b0;
      if (i < 4)
        rb = i;
      if (i == 0 || i == 4 || i == 15)
        mb = i;
      r(12'hF82, 2'h2, 8'(mb * 16 + rb));
    end
    r(12'hF83, 2'h1, 8'(mb));
    w(12'hF82, 2'h2, 2'h0, 8'h21);
    r(12'hF82, 2'h1, 8'(rb));
    e = 8'($urandom) & 8'h0F;
    w(12'hF84, 2'h1, 2'h0, e);
    w(12'hF84, 2'h2, 2'h0, 8'hFF);
    r(12'hF84, 2'h1, e);
    r(12'hF84, 2'h2, 8'h00);
    // single-bit writes only at bit three
    foreach (md[k])
    begin
      w(md[k], 2'h2, 2'h0, 8'h00);
      for (b = 0; b < 4; b++)
        w(md[k], 2'h0, b[1:0], 8'h01);
      r(md[k], 2'h2, 8'h08);
    end
    w(12'hF85, 2'h1, 2'h0, 8'h05);
    w(12'hF85, 2'h0, 2'h1, 8'h00);
    w(12'hF85, 2'h0, 2'h3, 8'h01);
    check("itm", {4'h0, interval_timer_mode_o}, 8'h0D);
    r(12'hF85, 2'h1, 8'h00);
    itv_count_i = 8'($urandom);
    t0_count_i = 8'($urandom);
    t1_count_i = 8'($urandom);
    t2_count_i = 8'($urandom);
    r(12'hF86, 2'h2, itv_count_i);
    r(12'hF94, 2'h2, t2_count_i);
    r(12'hFA4, 2'h2, t0_count_i);
    r(12'hFAC, 2'h2, t1_count_i);
    r(12'hFA4, 2'h1, 8'h00);
    // timer two control, upper bit three kept zero
    w(12'hF92, 2'h1, 2'h0, 8'h0F);
    r(12'hF92, 2'h1, 8'h07);
    check("oe", {5'h00, timer_out_enable_o}, 8'h04);
    e = 8'($urandom) & 8'h77;
    w(12'hF92, 2'h2, 2'h0, e);
    r(12'hF92, 2'h2, e);
    check("tc2", {5'h00, timer2_control_o}, {5'h00, e[2:0]});
    check("tc2h", {5'h00, timer2_control_hi_o}, {5'h00, e[6:4]});
    {t2_raw_i, t1_raw_i, t0_raw_i} = 3'h7;
    @(negedge clk_i);
    check("pin", {5'h00, timer_pin_o}, 8'h00);
    w(12'hFA2, 2'h0, 2'h3, 8'h01);
    w(12'hFAA, 2'h0, 2'h3, 8'h01);
    @(negedge clk_i);
    check("pin", {5'h00, timer_pin_o}, 8'h03);
    r(12'hFA2, 2'h0, 8'h00);
    // unmounted places and an odd byte access
    w(12'hF8A, 2'h1, 2'h0, 8'h0F);
    r(12'hF8A, 2'h1, 8'h00);
    r(12'hF98, 2'h2, 8'h00);
    w(12'hF97, 2'h2, 2'h0, 8'hA5);
    r(12'hF96, 2'h2, mem[12'hF96]);
    summarize;
  end
endmodule // peripheral_io_register_map_tb_top
